// File: verilog/dsl_core.sv
// Setting lock, command source selection, alarm log and status lamps
`timescale 1ns/1ns
`include "dsl_regs.svh"
module dsl_core
  import dsl_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = `DSL_FLASH_MS * 1000000 / `DSL_CLK_NS
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic forward_run_input_in,
  input wire logic reverse_run_input_in,
  input wire logic key_up_in,
  input wire logic key_down_in,
  input wire logic key_run_in,
  input wire logic key_stop_in,
  input wire logic key_lock_raise_in,
  input wire logic key_lock_lower_in,
  input wire logic key_wr_in,
  input wire logic [15:0] key_addr_in,
  input wire logic [15:0] key_data_in,
  input wire logic comm_wr_in,
  input wire logic [15:0] comm_addr_in,
  input wire logic [15:0] comm_data_in,
  input wire logic [15:0] rd_addr_in,
  input wire logic comm_freq_valid_in,
  input wire logic [15:0] comm_freq_in,
  input wire logic multistep_valid_in,
  input wire logic [15:0] multistep_freq_in,
  input wire logic comm_run_valid_in,
  input wire logic comm_run_fwd_in,
  input wire logic comm_run_rev_in,
  input wire logic alarm_raise_in,
  input wire logic [7:0] alarm_code_in,
  input wire logic alarm_reset_in,
  input wire logic comm_err_in,
  input wire logic [15:0] comm_err_type_in,
  output logic [15:0] rd_data_out,
  output logic [15:0] freq_ref_out,
  output logic run_fwd_out,
  output logic run_rev_out,
  output logic alarm_output_out,
  output logic red_led_out,
  output logic green_led_out,
  output logic wr_reject_out
);

  // ==========================================================================
  // State
  dsl_state_s s_q;
  dsl_state_s s_d;
  logic [7:0] pins;
  logic [7:0] rise;
  logic wr_en;
  logic wr_key;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic wr_ok;
  logic mock_go;
  logic clr_go;
  logic raise;
  logic [7:0] raise_code;
  logic tick;
  logic [4:0] flashes;
  logic [4:0] seq_len;

  // Flash count per alarm group; zero means steady on
  function automatic logic [4:0] flash_count(input logic [7:0] code);
    logic [4:0] n;
    n = 5'h00;
    case (code) // [R14] [R15]
      8'h01, 8'h02, 8'h03: n = 5'h05;
      8'h06, 8'h07, 8'h08, 8'h0a: n = 5'h03;
      8'h11, 8'h16: n = 5'h07;
      8'h17, 8'h19: n = 5'h08;
      8'h1f, 8'h21, 8'h3d: n = 5'h00;
      8'h25: n = 5'h02;
      8'h26: n = 5'h01;
      8'h2e: n = 5'h09;
      8'h33: n = 5'h03;
      8'hfe: n = 5'h04;
      default: n = 5'h00;
    endcase
    return n;
  endfunction

  // Pins only after two flops; third stage gives edges
  assign pins = {key_lock_lower_in, key_lock_raise_in, key_stop_in, key_run_in,
                 key_down_in, key_up_in, reverse_run_input_in, forward_run_input_in};
  assign rise = s_q.s2 & ~s_q.s3;

  // Link write wins the slot when both parties write together
  assign wr_key = key_wr_in & ~comm_wr_in;
  assign wr_en = key_wr_in | comm_wr_in;
  assign wr_addr = comm_wr_in ? comm_addr_in : key_addr_in;
  assign wr_data = comm_wr_in ? comm_data_in : key_data_in;

  // ==========================================================================
  // Write acceptance
  always_comb begin
    wr_ok = 1'b0;
    case (wr_addr)
      // Keypad can never write the lock selector directly
      `DSL_ADDR_LOCK: wr_ok = ~wr_key && wr_data <= `DSL_LOCK_MAX; // [R2] [R3] [R23]
      `DSL_ADDR_FSRC: wr_ok = wr_data == 16'h0000; // [R5]
      `DSL_ADDR_RSRC: begin
        wr_ok = wr_data >= `DSL_RSRC_MIN && wr_data <= `DSL_RSRC_MAX &&
                ~s_q.s2[`DSL_PIN_FWD] && ~s_q.s2[`DSL_PIN_REV]; // [R10] [R23]
      end
      `DSL_ADDR_LOGCLR, `DSL_ADDR_MOCK: wr_ok = wr_data <= `DSL_FLAG_MAX;
      default: wr_ok = 1'b0; // [R13] [R23]
    endcase
    // Settings lock gates keypad edits only; link writes pass
    if (wr_key && s_q.lock[0] && wr_addr != `DSL_ADDR_LOCK) begin
      wr_ok = 1'b0; // [R1] [R2] [R4]
    end
    wr_ok = wr_ok & wr_en;
  end

  // Self-clearing triggers never hold a stored one
  assign mock_go = wr_ok && wr_addr == `DSL_ADDR_MOCK && wr_data[0]; // [R20]
  assign clr_go = wr_ok && wr_addr == `DSL_ADDR_LOGCLR && wr_data[0]; // [R21]
  assign raise = alarm_raise_in | mock_go;
  // A real alarm beats a mock one arriving in the same cycle
  assign raise_code = alarm_raise_in ? alarm_code_in : `DSL_MOCK_CODE;

  // Lamp slot timing
  assign tick = s_q.tick_cnt == 28'(FLASH_CYCLES - 1);
  assign flashes = flash_count(s_q.act);
  assign seq_len = 5'({flashes, 1'b0}) + `DSL_GAP_SLOTS;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.rej = wr_en & ~wr_ok;
    // Selector writes
    if (wr_ok && wr_addr == `DSL_ADDR_LOCK) begin
      s_d.lock = wr_data[1:0]; // [R4]
    end
    if (wr_ok && wr_addr == `DSL_ADDR_FSRC) begin
      s_d.fsrc = wr_data[0]; // [R5]
    end
    if (wr_ok && wr_addr == `DSL_ADDR_RSRC) begin
      s_d.run_src = wr_data[1:0];
    end
    // Two-key press steps the lock selector between 0 and 1
    if (rise[`DSL_PIN_RAISE] && s_q.lock == 2'h0) begin
      s_d.lock = 2'h1; // [R3]
    end else if (rise[`DSL_PIN_LOWER] && s_q.lock == 2'h1) begin
      s_d.lock = 2'h0; // [R3]
    end
    // Keypad reference steps unless reference lock is on
    if (!s_q.lock[1] && s_q.fsrc == `DSL_FSRC_RST) begin
      if (rise[`DSL_PIN_UP] && s_q.kref != 16'hffff) begin
        s_d.kref = s_q.kref + 16'h0001; // [R1] [R5]
      end else if (rise[`DSL_PIN_DOWN] && s_q.kref != 16'h0000) begin
        s_d.kref = s_q.kref - 16'h0001;
      end
    end
    // Keypad run latch, cleared on stop or while the terminals are the run source
    if (rise[`DSL_PIN_STOP] || s_q.run_src == `DSL_RSRC_RST) begin
      s_d.key_run = 1'b0;
    end else if (rise[`DSL_PIN_RUN]) begin
      s_d.key_run = 1'b1;
    end
    // Reference priority: link, then multistep, then keypad
    if (comm_freq_valid_in) begin
      s_d.freq = comm_freq_in; // [R6]
    end else if (multistep_valid_in) begin
      s_d.freq = multistep_freq_in; // [R6]
    end else begin
      s_d.freq = s_q.kref;
    end
    // Run command priority: link, then selected source
    if (comm_run_valid_in) begin
      s_d.forward_run_input = comm_run_fwd_in & ~comm_run_rev_in; // [R11]
      s_d.reverse_run_input = comm_run_rev_in & ~comm_run_fwd_in;
    end else begin
      case (s_q.run_src)
        2'h1: begin
          // Both terminals on is treated as stop
          s_d.forward_run_input = s_q.s2[`DSL_PIN_FWD] & ~s_q.s2[`DSL_PIN_REV]; // [R7] [R12]
          s_d.reverse_run_input = s_q.s2[`DSL_PIN_REV] & ~s_q.s2[`DSL_PIN_FWD]; // [R7]
        end
        2'h2: begin
          s_d.forward_run_input = s_q.key_run; // [R8]
          s_d.reverse_run_input = 1'b0;
        end
        2'h3: begin
          s_d.forward_run_input = 1'b0;
          s_d.reverse_run_input = s_q.key_run; // [R9]
        end
        default: begin
          s_d.forward_run_input = 1'b0;
          s_d.reverse_run_input = 1'b0;
        end
      endcase
    end
    // Alarm log: clear first so a same-cycle alarm survives
    if (clr_go) begin
      s_d.h0 = 8'h00; // [R21]
      s_d.h1 = 8'h00;
      s_d.h2 = 8'h00;
      s_d.h3 = 8'h00;
    end
    if (alarm_reset_in) begin
      s_d.alarm_on = 1'b0;
    end
    if (raise) begin
      s_d.act = raise_code; // [R13]
      s_d.alarm_on = 1'b1;
      s_d.h0 = raise_code; // [R18] [R22]
      s_d.h1 = clr_go ? 8'h00 : s_q.h0;
      s_d.h2 = clr_go ? 8'h00 : s_q.h1;
      s_d.h3 = clr_go ? 8'h00 : s_q.h2;
    end
    if (comm_err_in) begin
      s_d.comm_detail = comm_err_type_in; // [R19]
    end
    // Lamps: green toggles each slot, red walks the flash sequence
    s_d.tick_cnt = tick ? 28'h0000000 : s_q.tick_cnt + 28'h0000001;
    if (tick) begin
      s_d.green = ~s_q.green; // [R17]
      s_d.step = (s_q.step >= seq_len - 5'h01) ? 5'h00 : s_q.step + 5'h01;
    end
    if (!s_q.alarm_on) begin
      s_d.step = 5'h00;
      s_d.red = 1'b0; // [R16]
    end else if (flashes == 5'h00) begin
      s_d.red = 1'b1; // [R16]
    end else begin
      s_d.red = s_q.step < {flashes[3:0], 1'b0} && !s_q.step[0]; // [R16]
    end
    // Read port, one cycle behind the address
    case (rd_addr_in)
      `DSL_ADDR_LOCK: s_d.rd_data = {14'h0000, s_q.lock};
      `DSL_ADDR_FSRC: s_d.rd_data = {15'h0000, s_q.fsrc};
      `DSL_ADDR_RSRC: s_d.rd_data = {14'h0000, s_q.run_src};
      `DSL_ADDR_ACTIVE: s_d.rd_data = {8'h00, s_q.act}; // [R13]
      `DSL_ADDR_COMMERR: s_d.rd_data = s_q.comm_detail; // [R19]
      `DSL_ADDR_HIST0: s_d.rd_data = {8'h00, s_q.h0}; // [R18]
      `DSL_ADDR_HIST1: s_d.rd_data = {8'h00, s_q.h1};
      `DSL_ADDR_HIST2: s_d.rd_data = {8'h00, s_q.h2};
      `DSL_ADDR_HIST3: s_d.rd_data = {8'h00, s_q.h3};
      default: s_d.rd_data = 16'h0000; // [R20] [R21]
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.lock <= `DSL_LOCK_RST;
      s_q.fsrc <= `DSL_FSRC_RST;
      s_q.run_src <= `DSL_RSRC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_out = s_q.rd_data;
  assign freq_ref_out = s_q.freq;
  assign run_fwd_out = s_q.forward_run_input;
  assign run_rev_out = s_q.reverse_run_input;
  assign alarm_output_out = s_q.alarm_on;
  assign red_led_out = s_q.red;
  assign green_led_out = s_q.green;
  assign wr_reject_out = s_q.rej;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence mock_wr_s;
    comm_wr_in && comm_addr_in == `DSL_ADDR_MOCK && comm_data_in == 16'h0001 &&
      !alarm_raise_in;
  endsequence
  sequence mock_seen_s;
    alarm_output_out && s_q.act == `DSL_MOCK_CODE && s_q.h0 == `DSL_MOCK_CODE;
  endsequence

  key_lock_blocks_a: assert property ( // [R1]
    key_wr_in && !comm_wr_in && s_q.lock[0] |=> wr_reject_out)
    else $error("keypad write passed settings lock");
  lock_combo_up_a: assert property ( // [R3]
    rise[`DSL_PIN_RAISE] && s_q.lock == 2'h0 && !comm_wr_in |=> s_q.lock == 2'h1)
    else $error("two-key raise did not set lock to 1");
  link_write_pass_a: assert property ( // [R4]
    comm_wr_in && comm_addr_in == `DSL_ADDR_FSRC && comm_data_in == 16'h0000
      |=> !wr_reject_out)
    else $error("link write refused under lock");
  run_src_frozen_a: assert property ( // [R10]
    wr_en && wr_addr == `DSL_ADDR_RSRC && (s_q.s2[`DSL_PIN_FWD] || s_q.s2[`DSL_PIN_REV])
      |=> $stable(s_q.run_src) && wr_reject_out)
    else $error("run source changed while terminal on");
  freq_priority_a: assert property ( // [R6]
    comm_freq_valid_in |=> freq_ref_out == $past(comm_freq_in))
    else $error("link reference lost priority");
  key_fwd_only_a: assert property ( // [R8]
    !comm_run_valid_in && s_q.run_src == 2'h2 |=> !run_rev_out)
    else $error("keypad forward mode ran reverse");
  key_rev_only_a: assert property ( // [R9]
    !comm_run_valid_in && s_q.run_src == 2'h3 |=> !run_fwd_out)
    else $error("keypad reverse mode ran forward");
  link_run_wins_a: assert property ( // [R11]
    comm_run_valid_in && comm_run_fwd_in && !comm_run_rev_in |=> run_fwd_out)
    else $error("link run command ignored");
  hist_shift_a: assert property ( // [R22]
    alarm_raise_in && !clr_go |=> s_q.h0 == $past(alarm_code_in) &&
      s_q.h1 == $past(s_q.h0) && s_q.h3 == $past(s_q.h2))
    else $error("history did not shift");
  mock_alarm_a: assert property ( // [R20]
    mock_wr_s |=> mock_seen_s)
    else $error("mock alarm not raised");
  log_clear_a: assert property ( // [R21]
    clr_go && !raise |=> s_q.h0 == 8'h00 && s_q.h3 == 8'h00)
    else $error("log clear left history");
  red_off_a: assert property ( // [R16]
    !alarm_output_out |=> !red_led_out)
    else $error("red lamp lit without alarm");
  green_flash_a: assert property ( // [R17]
    tick |=> green_led_out != $past(green_led_out))
    else $error("green lamp missed a slot");

endmodule // dsl_core

// File: include/dsl_regs.svh
// Register offsets, reset values, pin indices and timing counts of the setting lock block
// ==========================================================================
// Overview of operation
// [R1] Lock selector: 0 none, 1 settings, 2 reference, 3 both
// [R2] Settings lock never covers the lock selector
// [R3] Lock selector changes only by two-key press; here serial link writes also change it
// [R4] Serial link writes ignore the settings lock
// [R5] Frequency source accepts only value zero
// [R6] Link or multistep reference beats keypad reference
// [R7] Run source 1: terminals run forward/reverse
// [R8] Run source 2: keypad run, always forward
// [R9] Run source 3: keypad run, always reverse
// [R10] Run source frozen while a terminal is on
// [R11] Link run command beats selected run source
// [R12] Host holds terminals off before assigning them
// [R13] Active alarm register holds newest alarm, read-only
// [R14] Codes 1-3,6-8,10,17,22 for listed alarms
// [R15] Codes 23,25,31,33,37,38,46,51,61,254 for others
// [R16] Red lamp off normally, flashes alarm group
// [R17] Green lamp flashes continuously while powered
// [R18] Four-deep alarm history, first slot newest
// [R19] Serial error type latched in own register
// [R20] Test trigger raises mock alarm, self-clears
// [R21] Log clear erases history, self-clears
// [R22] New alarm shifts history one place older
// [R23] Read-only writes ignored, out-of-range values rejected
`ifndef DSL_REGS_SVH
`define DSL_REGS_SVH
// ==========================================================================
// Register offsets
`define DSL_ADDR_LOCK 16'h0000
`define DSL_ADDR_FSRC 16'h0001
`define DSL_ADDR_RSRC 16'h0002
`define DSL_ADDR_LOGCLR 16'h0314
`define DSL_ADDR_MOCK 16'h031e
`define DSL_ADDR_ACTIVE 16'h0502
`define DSL_ADDR_COMMERR 16'h050b
`define DSL_ADDR_HIST0 16'h050c
`define DSL_ADDR_HIST1 16'h050d
`define DSL_ADDR_HIST2 16'h050e
`define DSL_ADDR_HIST3 16'h050f
// ==========================================================================
// Reset values and legal ranges
`define DSL_LOCK_RST 2'h0
`define DSL_LOCK_MAX 16'h0003
`define DSL_FSRC_RST 1'h0
`define DSL_RSRC_RST 2'h1
`define DSL_RSRC_MIN 16'h0001
`define DSL_RSRC_MAX 16'h0003
`define DSL_FLAG_MAX 16'h0001
`define DSL_MOCK_CODE 8'hfe
`define DSL_COMM_CODE 8'h26
// ==========================================================================
// Synchronised pin indices
`define DSL_PIN_FWD 0
`define DSL_PIN_REV 1
`define DSL_PIN_UP 2
`define DSL_PIN_DOWN 3
`define DSL_PIN_RUN 4
`define DSL_PIN_STOP 5
`define DSL_PIN_RAISE 6
`define DSL_PIN_LOWER 7
// ==========================================================================
// Lamp timing: one flash slot in milliseconds, clock period in ns
`define DSL_FLASH_MS 250
`define DSL_CLK_NS 8
`define DSL_GAP_SLOTS 5'h04
`endif

// File: include/dsl_pkg.sv
// Types shared by the setting lock and alarm log block
package dsl_pkg;
  // Whole state of the core, registered once per clock
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [1:0] lock;
    logic fsrc;
    logic [1:0] run_src;
    logic [15:0] kref;
    logic key_run;
    logic alarm_on;
    logic [7:0] act;
    logic [7:0] h0;
    logic [7:0] h1;
    logic [7:0] h2;
    logic [7:0] h3;
    logic [15:0] comm_detail;
    logic [27:0] tick_cnt;
    logic [4:0] step;
    logic green;
    logic red;
    logic [15:0] rd_data;
    logic [15:0] freq;
    logic forward_run_input;
    logic reverse_run_input;
    logic rej;
  } dsl_state_s;
endpackage

// File: sim/dsl_far_side.sv
// Far-side model: keypad, run terminals and serial-link master
`timescale 1ns/1ns
module dsl_far_side (
  input wire logic clock_in,
  output logic forward_run_input_in,
  output logic reverse_run_input_in,
  output logic key_up_in,
  output logic key_down_in,
  output logic key_run_in,
  output logic key_stop_in,
  output logic key_lock_raise_in,
  output logic key_lock_lower_in,
  output logic key_wr_in,
  output logic [15:0] key_addr_in,
  output logic [15:0] key_data_in,
  output logic comm_wr_in,
  output logic [15:0] comm_addr_in,
  output logic [15:0] comm_data_in,
  output logic [15:0] rd_addr_in,
  output logic comm_freq_valid_in,
  output logic [15:0] comm_freq_in,
  output logic multistep_valid_in,
  output logic [15:0] multistep_freq_in,
  output logic comm_run_valid_in,
  output logic comm_run_fwd_in,
  output logic comm_run_rev_in
);
  logic [7:0] pins_q;
  // ==========
  // Key and terminal levels, one bit per pin index
  assign {key_lock_lower_in, key_lock_raise_in, key_stop_in, key_run_in, key_down_in, key_up_in,
    reverse_run_input_in, forward_run_input_in} = pins_q;
  // Everything idle at time zero, terminals off
  initial begin
    pins_q = 8'h00;
    {key_wr_in, comm_wr_in, comm_freq_valid_in, multistep_valid_in} = 4'h0;
    {comm_run_valid_in, comm_run_fwd_in, comm_run_rev_in} = 3'h0;
    {key_addr_in, key_data_in, comm_addr_in, comm_data_in} = 64'h0;
    {rd_addr_in, comm_freq_in, multistep_freq_in} = 48'h0;
  end
  // One write strobe; released lines are inverted so stale values never pass as fresh
  task automatic bus_wr(input bit kp, input logic [15:0] a, input logic [15:0] d);
    @(negedge clock_in);
    if (kp) begin
      {key_wr_in, key_addr_in, key_data_in} = {1'b1, a, d};
    end else begin
      {comm_wr_in, comm_addr_in, comm_data_in} = {1'b1, a, d};
    end
    @(negedge clock_in);
    {key_wr_in, comm_wr_in} = 2'h0;
    {key_addr_in, key_data_in, comm_addr_in, comm_data_in} = ~{a, d, a, d};
  endtask
  // Keys are held past the synchroniser and edge detector, combos as one press
  task automatic press(input int idx);
    @(negedge clock_in);
    pins_q[idx] = 1'b1;
    repeat (5) @(negedge clock_in);
    pins_q[idx] = 1'b0;
    repeat (5) @(negedge clock_in);
  endtask
  // Terminal level change, then settle time for the synchroniser
  task automatic set_pin(input int idx, input bit v);
    @(negedge clock_in);
    pins_q[idx] = v;
    repeat (6) @(negedge clock_in);
  endtask
  task automatic point(input logic [15:0] a);
    @(negedge clock_in);
    rd_addr_in = a;
  endtask
  // Link reference, multistep reference and link run command
  task automatic link(input bit cv, input logic [15:0] c, input bit mv, input logic [15:0] m,
      input bit rv, input bit rf, input bit rr);
    @(negedge clock_in);
    {comm_freq_valid_in, comm_freq_in, multistep_valid_in, multistep_freq_in} = {cv, c, mv, m};
    {comm_run_valid_in, comm_run_fwd_in, comm_run_rev_in} = {rv, rf, rr};
    repeat (3) @(negedge clock_in);
  endtask
endmodule // dsl_far_side

// File: sim/testbench.sv
// Self-checking bench for the setting lock and alarm log core
`timescale 1ns/1ns
`include "dsl_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module testbench;
  logic clock_in, rst_n_in, forward_run_input_in, reverse_run_input_in, key_up_in, key_down_in;
  logic key_run_in, key_stop_in, key_lock_raise_in, key_lock_lower_in, key_wr_in, comm_wr_in;
  logic comm_freq_valid_in, multistep_valid_in, comm_run_valid_in, comm_run_fwd_in;
  logic comm_run_rev_in, alarm_raise_in, alarm_reset_in, comm_err_in, run_fwd_out, run_rev_out;
  logic alarm_output_out, red_led_out, green_led_out, wr_reject_out;
  logic [7:0] alarm_code_in;
  logic [15:0] key_addr_in, key_data_in, comm_addr_in, comm_data_in, rd_addr_in, comm_freq_in;
  logic [15:0] multistep_freq_in, comm_err_type_in, rd_data_out, freq_ref_out;
  int bad_count, checks_done, cycles, g_tog, r_on;
  int lock, fsrc, rsrc = 1, kref, act, cerr, kr, tf, tr, cv, cf, mv, mf, rv, rf, rr;
  int h[$] = '{0, 0, 0, 0};
  int addrs[] = '{0, 1, 2, 'h314, 'h31e, 'h502, 'h50b, 'h50c, 'h50d, 'h50e, 'h50f, 'h123};
  int codes[] = '{1, 2, 3, 6, 7, 8, 10, 17, 22, 23, 25, 31, 33, 37, 38, 46, 51, 61};
  int bad_a[] = '{0, 1, 2, 2, 'h502, 'h50c, 'h50f, 'h314, 'h31e, 'h40};
  int bad_d[] = '{4, 1, 0, 4, 5, 5, 5, 2, 2, 1};

  // Short flash slots keep lamp checks quick
  dsl_core #(.FLASH_CYCLES(4)) dut_u (.*);
  dsl_far_side far_u (.*);

  // ==========
  // Clock and hang guard
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  // ==========
  // Reference model
  function automatic int reg_val(input int a);
    if (a >= 'h50c && a <= 'h50f) return h[a - 'h50c];
    case (a)
      0: return lock;
      1: return fsrc;
      2: return rsrc;
      'h502: return act;
      'h50b: return cerr;
      default: return 0;
    endcase
  endfunction
  task automatic log_alarm(input int c);
    h.push_front(c);
    void'(h.pop_back());
    act = c;
  endtask
  // Outputs follow link command first, then the selected source
  task automatic chk_out();
    int ef;
    int er;
    ef = rv ? rf : rsrc == 1 ? tf && !tr : rsrc == 2 ? kr : 0;
    er = rv ? rr : rsrc == 1 ? tr && !tf : rsrc == 3 ? kr : 0;
    `CHK(freq_ref_out, cv ? cf : mv ? mf : kref)
    `CHK(run_fwd_out, ef)
    `CHK(run_rev_out, er)
  endtask
  task automatic rd(input int a);
    far_u.point(a[15:0]);
    repeat (2) @(negedge clock_in);
    `CHK(rd_data_out, reg_val(a))
  endtask
  task automatic check_all();
    foreach (addrs[i]) rd(addrs[i]);
  endtask
  // Refusal is predicted before the write, the model moves only if it is taken
  task automatic wr(input int kp, input int a, input int d);
    int ok;
    int pl;
    pl = kp && lock[0];
    case (a)
      0: ok = !kp && d <= 3;
      1: ok = !pl && d == 0;
      2: ok = !pl && d >= 1 && d <= 3 && !tf && !tr;
      'h314, 'h31e: ok = !pl && d <= 1;
      default: ok = 0;
    endcase
    far_u.bus_wr(kp[0], a[15:0], d[15:0]);
    // Reject flag stands for one cycle only, so look at it as the strobe drops
    `CHK(wr_reject_out, !ok)
    if (ok && a == 0) lock = d;
    if (ok && a == 1) fsrc = d;
    if (ok && a == 2) rsrc = d;
    if (ok && a == 2 && d == 1) kr = 0;
    if (ok && a == 'h314 && d == 1) h = '{0, 0, 0, 0};
    if (ok && a == 'h31e && d == 1) log_alarm(254);
  endtask
  task automatic key(input int idx);
    far_u.press(idx);
    case (idx)
      `DSL_PIN_UP: if (lock < 2 && kref < 'hffff) kref++;
      `DSL_PIN_DOWN: if (lock < 2 && kref > 0) kref--;
      `DSL_PIN_RUN: kr = rsrc != 1;
      `DSL_PIN_STOP: kr = 0;
      `DSL_PIN_RAISE: if (lock == 0) lock = 1;
      default: if (lock == 1) lock = 0;
    endcase
    chk_out();
  endtask
  task automatic term(input int idx, input int v);
    far_u.set_pin(idx, v[0]);
    if (idx == `DSL_PIN_FWD) tf = v;
    else tr = v;
    chk_out();
  endtask
  task automatic link_set(input int c_v, input int m_v, input int r_v, input int r_f);
    cv = c_v;
    mv = m_v;
    rv = r_v;
    rf = r_f;
    rr = r_v && !r_f;
    cf = $urandom_range(16'hffff);
    mf = $urandom_range(16'hffff);
    far_u.link(cv[0], cf[15:0], mv[0], mf[15:0], rv[0], rf[0], rr[0]);
    chk_out();
  endtask
  task automatic alarm(input int c);
    @(negedge clock_in);
    alarm_code_in = c[7:0];
    alarm_raise_in = 1'b1;
    @(negedge clock_in);
    alarm_raise_in = 1'b0;
    alarm_code_in = ~c[7:0];
    log_alarm(c);
    `CHK(alarm_output_out, 1)
  endtask
  task automatic lamp_watch(input int n);
    logic g;
    g_tog = 0;
    r_on = 0;
    repeat (n) begin
      g = green_led_out;
      @(negedge clock_in);
      if (green_led_out !== g) g_tog++;
      if (red_led_out === 1'b1) r_on++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'hbce60c27));
    {alarm_raise_in, alarm_reset_in, comm_err_in, rst_n_in} = 4'h0;
    alarm_code_in = 8'h00;
    comm_err_type_in = 16'h0000;
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
    rst_n_in = 1'b1;
    check_all();
    foreach (bad_a[i]) wr(0, bad_a[i], bad_d[i]);
    // Every lock level against keypad edits and link writes
    for (int l = 0; l < 4; l++) begin
      wr(0, 0, l);
      wr(1, 1, 0);
      wr(1, 2, 2);
      key(`DSL_PIN_UP);
      check_all();
    end
    wr(0, 0, 0);
    key(`DSL_PIN_DOWN);
    wr(1, 0, 1);
    key(`DSL_PIN_RAISE);
    key(`DSL_PIN_RAISE);
    rd(0);
    key(`DSL_PIN_LOWER);
    rd(0);
    for (int m = 0; m < 4; m++) link_set(m / 2, m % 2, 0, 0);
    // Terminals released before they gain control
    term(`DSL_PIN_FWD, 0);
    wr(0, 2, 1);
    term(`DSL_PIN_FWD, 1);
    wr(0, 2, 2);
    term(`DSL_PIN_REV, 1);
    term(`DSL_PIN_FWD, 0);
    term(`DSL_PIN_REV, 0);
    wr(0, 2, 2);
    key(`DSL_PIN_RUN);
    key(`DSL_PIN_STOP);
    wr(0, 2, 3);
    key(`DSL_PIN_RUN);
    link_set(0, 0, 1, 1);
    link_set(0, 0, 1, 0);
    link_set(0, 0, 0, 0);
    key(`DSL_PIN_STOP);
    // Each code enters the four-slot history, read back after every sixth alarm
    foreach (codes[i]) begin
      alarm(codes[i]);
      if (i % 6 == 5) check_all();
    end
    lamp_watch(200);
    `CHK(g_tog, 50)
    `CHK(r_on > 0, 1)
    @(negedge clock_in);
    alarm_reset_in = 1'b1;
    @(negedge clock_in);
    alarm_reset_in = 1'b0;
    @(negedge clock_in);
    `CHK(alarm_output_out, 0)
    lamp_watch(60);
    `CHK(r_on, 0)
    wr(0, 'h31e, 1);
    lamp_watch(200);
    `CHK(r_on > 0, 1)
    check_all();
    wr(0, 'h314, 1);
    check_all();
    alarm(codes[$urandom_range(17)]);
    check_all();
    @(negedge clock_in);
    comm_err_in = 1'b1;
    comm_err_type_in = 16'($urandom_range(16'hffff));
    cerr = comm_err_type_in;
    @(negedge clock_in);
    comm_err_in = 1'b0;
    comm_err_type_in = ~comm_err_type_in;
    rd('h50b);
    close_out();
  end
endmodule // testbench
